// ==== hdl/rtip_ctl.sv ====
`timescale 1ns/100ps
`default_nettype none
// How it works
// - All instructions do nothing when absent, switch off, non-executive or program state.
// - Clear-processor erases pending and active interrupts, enable and auto-disable.
// - Clear-processor leaves line mask and base address unchanged.
// - Clear-mask resets mask bits of group g where code bit is one.
// - Group g covers lines 8g..8g+7; code bit 0 is the lowest line.
// - Set-mask sets selected group bits where code bit is one, others kept.
// - Set-base loads instruction bits 8..2 as the seven-bit vector base.
// - Vector holds base in 14..8, line in 7..2, zeros in 1..0.
// - Force raises a pending request on each selected line of the group.
// - A request is recognized only if masked in, unblocked by priority, and enabled.
// - Turn-off blocks recognition until a later turn-on.
// - Internal clear, master clear and abnormal interrupt all disable the processor.
// - Turn-on lets recognition resume.
// - After abnormal interrupt while disabled, first turn-on ignored, second enables.
// - With auto-disable selected, the CPU taking a line disables the processor.
// - Auto-disable stays until deselect, clear-processor, internal clear or master clear.
// - Deselect cancels auto-disable.
// - Restore frees line l and lower-priority lines; lines below 16 restore registers.
// - From restore to next jump, all lines but the parity line are held off.
// - Restore-and-signal also raises a normal CPU interrupt when the flag is set.
// - Flag sets on CPU taking a line interrupt, clears on any normal interrupt.
// - Taking the restore interrupt stores code 0317 at location 5.
// - Taking lines below 16 saves then clears the condition register.
module rtip_ctl
	import rtip_pkg::*;
#(
	parameter int PARITY_LINE = 0
) (
	input wire logic clk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins from outside the clock domain
	input wire logic processorPresent,
	input wire logic line_processor_panel_switch,
	input wire logic [RTIP_LINES-1:0] extLines,
	// CPU execution logic, same clock
	input wire logic cpuExecutive,
	input wire logic cpuProgramState,
	input wire logic cpuInternalClear,
	input wire logic cpuAbnormalInt,
	input wire logic cpuJump,
	input wire logic cpuLineAck,
	input wire logic cpuNormalAck,
	output rtip_vec_t lineRequest,
	output logic normalIrq,
	output rtip_store_t restoreStore,
	output logic condSave,
	output rtip_line_evt_t regRestore
);

	logic [RTIP_LINES-1:0] extMeta_r;
	logic [RTIP_LINES-1:0] extSync_r;
	logic [1:0] strapMeta_r;
	logic [1:0] strapSync_r;
	logic [RTIP_LINES-1:0] mask_r;
	logic [RTIP_LINES-1:0] pend_r;
	logic [RTIP_LINES-1:0] active_r;
	logic [6:0] base_r;
	logic enable_r;
	logic auto_r;
	logic flag_r;
	logic hold_r;
	logic skipOn_r;
	logic [23:0] lastCmd_r;
	logic reqValid_r;
	logic [RTIP_LW-1:0] reqLine_r;
	logic normalIrq_r;
	rtip_store_t store_r;
	logic condSave_r;
	rtip_line_evt_t restore_r;

	logic wrAccess;
	logic cmdWrite;
	logic live;
	logic [23:0] cmd;
	logic isClear;
	logic isMisc;
	logic isRestore;
	logic isRestoreSig;
	logic [RTIP_LINES-1:0] groupBits;
	logic [RTIP_LW-1:0] cmdLine;
	logic [RTIP_LINES-1:0] freeMask;
	logic [RTIP_LINES-1:0] eligible;
	logic candFound;
	logic [RTIP_LW-1:0] candLine;
	logic actFound;
	logic [RTIP_LW-1:0] actLine;
	logic canIssue;
	logic takeLine;

	assign wrAccess = psel & penable & pwrite;
	assign cmdWrite = wrAccess & (paddr == ADDR_CMD);
	assign cmd = pwdata[23:0];
	assign live = strapSync_r[0] & strapSync_r[1] & cpuExecutive & ~cpuProgramState;
	assign isClear = cmdWrite & live & (cmd[OPC_HI:OPC_LO] == OPC_CLEAR) & (cmd[SUB_HI:SUB3_LO] == SUB3_CLEAR);
	assign isMisc = cmdWrite & live & (cmd[OPC_HI:OPC_LO] == OPC_MISC);
	assign isRestoreSig = cmdWrite & live & (cmd[OPC_HI:OPC_LO] == OPC_RESTORE)
		& (cmd[SUB_HI:SUB_LO] == SUB_RESTORE_SIG);
	assign isRestore = isRestoreSig | (cmdWrite & live & (cmd[OPC_HI:OPC_LO] == OPC_RESTORE)
		& (cmd[SUB_HI:SUB_LO] == SUB_RESTORE));
	assign cmdLine = cmd[LINE_HI:LINE_LO];
	assign groupBits = {{(RTIP_LINES-RTIP_GROUP_W){1'b0}}, cmd[CODE_HI:CODE_LO]}
		<< {cmd[GRP_HI:GRP_LO], 3'h0};
	assign freeMask = {RTIP_LINES{1'b1}} << cmdLine;

	always_ff @(posedge clk) begin
		extMeta_r <= extLines;
		extSync_r <= extMeta_r;
		strapMeta_r <= {line_processor_panel_switch, processorPresent};
		strapSync_r <= strapMeta_r;
	end

	// Eligible lines, with the parity line exempt from the restore hold-off
	always_comb begin
		eligible = pend_r & mask_r;
		if (hold_r) begin
			eligible = eligible & ({{(RTIP_LINES-1){1'b0}}, 1'b1} << PARITY_LINE);
		end
	end

	// Lowest line number wins
	always_comb begin
		candFound = 1'b0;
		candLine = '0;
		actFound = 1'b0;
		actLine = '0;
		for (int i = RTIP_LINES - 1; i >= 0; i--) begin
			if (eligible[i]) begin
				candFound = 1'b1;
				candLine = RTIP_LW'(i);
			end
			if (active_r[i]) begin
				actFound = 1'b1;
				actLine = RTIP_LW'(i);
			end
		end
	end

	assign canIssue = candFound & enable_r & (~actFound | (candLine < actLine)) & ~reqValid_r;
	assign takeLine = reqValid_r & cpuLineAck;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			mask_r <= '0;
		end else if (isMisc & (cmd[SUB_HI:SUB_LO] == SUB_CLR_MASK)) begin
			mask_r <= mask_r & ~groupBits;
		end else if (isMisc & (cmd[SUB_HI:SUB_LO] == SUB_SET_MASK)) begin
			mask_r <= mask_r | groupBits;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			base_r <= '0;
		end else if (isMisc & (cmd[SUB_HI:SUB_LO] == SUB_SET_BASE)) begin
			base_r <= cmd[BASE_HI:BASE_LO];
		end
	end

	// Pending requests; new arrivals win over the taking of a line
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pend_r <= '0;
		end else if (isClear) begin
			pend_r <= '0;
		end else begin
			pend_r <= (pend_r & ~(takeLine ? ({{(RTIP_LINES-1){1'b0}}, 1'b1} << reqLine_r) : '0))
				| extSync_r
				| ((isMisc & (cmd[SUB_HI:SUB_LO] == SUB_FORCE)) ? groupBits : '0);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			active_r <= '0;
		end else if (isClear) begin
			active_r <= '0;
		end else if (takeLine) begin
			active_r <= active_r | ({{(RTIP_LINES-1){1'b0}}, 1'b1} << reqLine_r);
		end else if (isRestore) begin
			active_r <= active_r & ~freeMask;
		end
	end

	// Request to the CPU, held until taken or withdrawn by a clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			reqValid_r <= 1'b0;
			reqLine_r <= '0;
		end else if (isClear | cpuInternalClear) begin
			reqValid_r <= 1'b0;
		end else if (takeLine) begin
			reqValid_r <= 1'b0;
		end else if (canIssue) begin
			reqValid_r <= 1'b1;
			reqLine_r <= candLine;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			enable_r <= 1'b0;
			skipOn_r <= 1'b0;
		end else if (cpuInternalClear) begin
			enable_r <= 1'b0;
			skipOn_r <= 1'b0;
		end else if (cpuAbnormalInt) begin
			enable_r <= 1'b0;
			skipOn_r <= ~enable_r;
		end else if (isClear) begin
			enable_r <= 1'b0;
		end else if (isMisc & (cmd[SUB_HI:SUB_LO] == SUB_TURN_ON)) begin
			if (skipOn_r) begin
				skipOn_r <= 1'b0;
			end else begin
				enable_r <= 1'b1;
			end
		end else if (isMisc & (cmd[SUB_HI:SUB_LO] == SUB_TURN_OFF)) begin
			enable_r <= 1'b0;
		end else if (takeLine & auto_r) begin
			enable_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			auto_r <= 1'b0;
		end else if (cpuInternalClear | isClear) begin
			auto_r <= 1'b0;
		end else if (isMisc & (cmd[SUB_HI:SUB_LO] == SUB_DESEL_AUTO)) begin
			auto_r <= 1'b0;
		end else if (isMisc & (cmd[SUB_HI:SUB_LO] == SUB_SEL_AUTO)) begin
			auto_r <= 1'b1;
		end
	end

	// Restore hold-off; a restore in the jump cycle keeps it set
	always_ff @(posedge clk) begin
		if (!resetn) begin
			hold_r <= 1'b0;
		end else if (isRestore) begin
			hold_r <= 1'b1;
		end else if (cpuJump) begin
			hold_r <= 1'b0;
		end
	end

	// Line-taken flag; a set wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			flag_r <= 1'b0;
		end else if (takeLine) begin
			flag_r <= 1'b1;
		end else if (cpuNormalAck) begin
			flag_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			normalIrq_r <= 1'b0;
		end else if (isRestoreSig & flag_r) begin
			normalIrq_r <= 1'b1;
		end else if (cpuNormalAck) begin
			normalIrq_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			store_r <= '0;
		end else begin
			store_r.valid <= normalIrq_r & cpuNormalAck;
			store_r.address <= RESTORE_ADDR;
			store_r.data <= RESTORE_CODE;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			condSave_r <= 1'b0;
			restore_r <= '0;
		end else begin
			condSave_r <= takeLine & (reqLine_r < SAVED_LINES);
			restore_r.valid <= isRestore & (cmdLine < SAVED_LINES);
			restore_r.line <= cmdLine;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			lastCmd_r <= '0;
		end else if (cmdWrite) begin
			lastCmd_r <= cmd;
		end
	end

	assign lineRequest.valid = reqValid_r;
	assign lineRequest.line = reqLine_r;
	assign lineRequest.address = {base_r, reqLine_r, 2'b00};
	assign normalIrq = normalIrq_r;
	assign restoreStore = store_r;
	assign condSave = condSave_r;
	assign regRestore = restore_r;

	assign pready = 1'b1;

	always_comb begin
		prdata = '0;
		pslverr = 1'b0;
		case (paddr)
			ADDR_CMD: prdata = {8'h00, lastCmd_r};
			ADDR_STATUS: begin
				prdata[ST_ENABLE] = enable_r;
				prdata[ST_AUTO] = auto_r;
				prdata[ST_FLAG] = flag_r;
				prdata[ST_HOLD] = hold_r;
				prdata[ST_SKIP_ON] = skipOn_r;
				prdata[ST_REQ] = reqValid_r;
				prdata[ST_NORMAL] = normalIrq_r;
				prdata[ST_LIVE] = live;
			end
			ADDR_MASK_LO: prdata = mask_r[31:0];
			ADDR_MASK_HI: prdata = mask_r[63:32];
			ADDR_PEND_LO: prdata = pend_r[31:0];
			ADDR_PEND_HI: prdata = pend_r[63:32];
			ADDR_ACTIVE_LO: prdata = active_r[31:0];
			ADDR_ACTIVE_HI: prdata = active_r[63:32];
			ADDR_VECTOR: prdata = {17'h00000, base_r, reqLine_r, 2'b00};
			default: pslverr = psel & penable;
		endcase
		if (pwrite && paddr != ADDR_CMD) begin
			pslverr = psel & penable;
		end
	end

endmodule : rtip_ctl
`default_nettype wire

// ==== hdl/rtip_pkg.sv ====
package rtip_pkg;
	localparam int RTIP_LINES = 64;
	localparam int RTIP_LW = 6;
	localparam int RTIP_GROUP_W = 8;
	// Instruction word fields
	localparam int OPC_HI = 23;
	localparam int OPC_LO = 18;
	localparam int SUB_HI = 17;
	localparam int SUB_LO = 12;
	localparam int SUB3_LO = 15;
	localparam int GRP_HI = 11;
	localparam int GRP_LO = 9;
	localparam int CODE_HI = 7;
	localparam int CODE_LO = 0;
	localparam int BASE_HI = 8;
	localparam int BASE_LO = 2;
	localparam int LINE_HI = 5;
	localparam int LINE_LO = 0;
	localparam logic [5:0] OPC_CLEAR = 6'h0d;
	localparam logic [5:0] OPC_MISC = 6'h0e;
	localparam logic [5:0] OPC_RESTORE = 6'h0f;
	localparam logic [5:0] SUB_CLR_MASK = 6'h00;
	localparam logic [5:0] SUB_SET_MASK = 6'h01;
	localparam logic [5:0] SUB_SET_BASE = 6'h02;
	localparam logic [5:0] SUB_FORCE = 6'h03;
	localparam logic [5:0] SUB_TURN_OFF = 6'h04;
	localparam logic [5:0] SUB_TURN_ON = 6'h05;
	localparam logic [5:0] SUB_SEL_AUTO = 6'h06;
	localparam logic [5:0] SUB_DESEL_AUTO = 6'h07;
	localparam logic [5:0] SUB_RESTORE = 6'h00;
	localparam logic [5:0] SUB_RESTORE_SIG = 6'h04;
	localparam logic [2:0] SUB3_CLEAR = 3'h0;
	// Lines below this number save and restore the condition register
	localparam logic [5:0] SAVED_LINES = 6'h10;
	// Restore interrupt store
	localparam logic [14:0] RESTORE_ADDR = 15'h0005;
	localparam logic [11:0] RESTORE_CODE = 12'h0cf;
	// APB map
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK_LO = 8'h08;
	localparam logic [7:0] ADDR_MASK_HI = 8'h0c;
	localparam logic [7:0] ADDR_PEND_LO = 8'h10;
	localparam logic [7:0] ADDR_PEND_HI = 8'h14;
	localparam logic [7:0] ADDR_ACTIVE_LO = 8'h18;
	localparam logic [7:0] ADDR_ACTIVE_HI = 8'h1c;
	localparam logic [7:0] ADDR_VECTOR = 8'h20;
	// Status bit positions
	localparam int ST_ENABLE = 0;
	localparam int ST_AUTO = 1;
	localparam int ST_FLAG = 2;
	localparam int ST_HOLD = 3;
	localparam int ST_SKIP_ON = 4;
	localparam int ST_REQ = 5;
	localparam int ST_NORMAL = 6;
	localparam int ST_LIVE = 7;

	typedef struct packed {
		logic valid;
		logic [RTIP_LW-1:0] line;
		logic [14:0] address;
	} rtip_vec_t;

	typedef struct packed {
		logic valid;
		logic [14:0] address;
		logic [11:0] data;
	} rtip_store_t;

	typedef struct packed {
		logic valid;
		logic [RTIP_LW-1:0] line;
	} rtip_line_evt_t;
endpackage : rtip_pkg

// ==== tb/rtip_ctl_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtip_ctl_monitor
	import rtip_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic cpuInternalClear,
	input wire logic cpuLineAck,
	input wire logic cpuNormalAck,
	input wire rtip_vec_t lineRequest,
	input wire logic normalIrq,
	input wire rtip_store_t restoreStore,
	input wire logic condSave,
	input wire rtip_line_evt_t regRestore
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_take;
		lineRequest.valid && cpuLineAck;
	endsequence
	sequence s_sig_ack;
		normalIrq && cpuNormalAck;
	endsequence
	property p_vec;
		lineRequest.valid |-> lineRequest.address[7:0] == {lineRequest.line, 2'b00};
	endproperty
	a_vec: assert property (p_vec) else $error("vector address malformed");
	property p_hold;
		lineRequest.valid && !cpuLineAck && !cpuInternalClear && !psel |=> $stable(lineRequest);
	endproperty
	a_hold: assert property (p_hold) else $error("request changed before take");
	property p_save;
		s_take ##0 (lineRequest.line < SAVED_LINES) |=> condSave;
	endproperty
	a_save: assert property (p_save) else $error("condition save missing");
	property p_save_cause;
		condSave |-> $past(lineRequest.valid && cpuLineAck && lineRequest.line < SAVED_LINES);
	endproperty
	a_save_cause: assert property (p_save_cause) else $error("condition save without take");
	property p_one;
		s_take |=> !lineRequest.valid;
	endproperty
	a_one: assert property (p_one) else $error("request not dropped after take");
	property p_irq_hold;
		normalIrq && !cpuNormalAck && !cpuInternalClear |=> normalIrq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("normal request dropped early");
	property p_store;
		s_sig_ack |=> restoreStore.valid && restoreStore.address == RESTORE_ADDR && restoreStore.data == RESTORE_CODE;
	endproperty
	a_store: assert property (p_store) else $error("restore store wrong");
	property p_irq_drop;
		s_sig_ack |=> !normalIrq;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("normal request kept after ack");
	property p_regrst;
		regRestore.valid |-> regRestore.line < SAVED_LINES;
	endproperty
	a_regrst: assert property (p_regrst) else $error("register restore on high line");
	property p_iclear;
		cpuInternalClear |=> !lineRequest.valid [*2];
	endproperty
	a_iclear: assert property (p_iclear) else $error("request after internal clear");
endmodule : rtip_ctl_monitor
bind rtip_ctl rtip_ctl_monitor rtip_ctl_monitor_inst (.clk(clk), .resetn(resetn), .psel(psel),
	.cpuInternalClear(cpuInternalClear), .cpuLineAck(cpuLineAck), .cpuNormalAck(cpuNormalAck),
	.lineRequest(lineRequest), .normalIrq(normalIrq), .restoreStore(restoreStore), .condSave(condSave),
	.regRestore(regRestore));
`default_nettype wire

// ==== tb/rtip_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtip_cpu_model
	import rtip_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] ackDelay,
	input wire rtip_vec_t lineRequest,
	input wire logic normalIrq,
	output logic cpuLineAck,
	output logic cpuNormalAck
);
	logic [3:0] waitCnt_r;
	// Takes a line request ackDelay+1 cycles after it appears, one pulse each
	always_ff @(posedge clk) begin
		if (!resetn || !lineRequest.valid || cpuLineAck) begin
			waitCnt_r <= 4'h0;
			cpuLineAck <= 1'b0;
		end else begin
			waitCnt_r <= waitCnt_r + 4'h1;
			cpuLineAck <= (waitCnt_r >= ackDelay);
		end
	end
	always_ff @(posedge clk) begin
		cpuNormalAck <= resetn && normalIrq && !cpuNormalAck;
	end
endmodule : rtip_cpu_model
`default_nettype wire

// ==== tb/rtip_ctl_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtip_ctl_tb_top
	import rtip_pkg::*;
;
	logic clk, resetn, psel, penable, pwrite, present, panelOn, cpuExec, cpuProg;
	logic pready, pslverr, normalIrq, condSave, lineAck, normalAck;
	logic [2:0] ev;
	logic [3:0] ackDelay;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	rtip_vec_t lineRequest, v;
	rtip_store_t restoreStore;
	rtip_line_evt_t regRestore;
	int fails, numChecks, n;
	rtip_ctl rtip_ctl_inst (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.processorPresent(present), .line_processor_panel_switch(panelOn), .extLines(64'h0),
		.cpuExecutive(cpuExec), .cpuProgramState(cpuProg), .cpuInternalClear(ev[2]), .cpuAbnormalInt(ev[1]),
		.cpuJump(ev[0]), .cpuLineAck(lineAck), .cpuNormalAck(normalAck), .lineRequest(lineRequest),
		.normalIrq(normalIrq), .restoreStore(restoreStore), .condSave(condSave), .regRestore(regRestore));
	rtip_cpu_model rtip_cpu_model_inst (.clk(clk), .resetn(resetn), .ackDelay(ackDelay),
		.lineRequest(lineRequest), .normalIrq(normalIrq), .cpuLineAck(lineAck), .cpuNormalAck(normalAck));
	always #25 clk = ~clk;
	task give_verdict;
		if (fails == 0 && numChecks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		numChecks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task tmo;
		fails++;
		give_verdict();
	endtask : tmo
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Sample the settled answer mid-cycle; it still stands at the next rising edge
		do begin
			@(negedge clk);
			n++;
			if (n > 20) tmo();
		end while (pready !== 1'b1);
		q = prdata;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task cmd(input logic [31:0] d);
		apb(1'b1, ADDR_CMD, d);
	endtask : cmd
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : rdc
	function logic [31:0] mi(input logic [5:0] sub, input logic [11:0] low);
		return {8'h00, OPC_MISC, sub, low};
	endfunction : mi
	function logic [31:0] rs(input logic [5:0] sub, input logic [5:0] line);
		return {8'h00, OPC_RESTORE, sub, 6'h00, line};
	endfunction : rs
	task pulse(input logic [2:0] m);
		ev <= m;
		@(posedge clk);
		ev <= 3'h0;
	endtask : pulse
	task waitTake;
		n = 0;
		do begin
			@(negedge clk);
			n++;
			if (n > 40) tmo();
		end while (!(lineRequest.valid === 1'b1 && lineAck === 1'b1));
		v = lineRequest;
		@(posedge clk);
	endtask : waitTake
	// Checks that no request is up six cycles later
	task quiet;
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk(lineRequest.valid, 1'b0);
		@(posedge clk);
	endtask : quiet
	task rel3;
		cmd(rs(SUB_RESTORE, 6'h03));
		pulse(3'h1);
	endtask : rel3
	task t_mask;
		cmd(mi(SUB_SET_MASK, 12'h202));
		cmd(mi(SUB_SET_MASK, 12'haff));
		rdc(ADDR_MASK_LO, 32'h00000200);
		rdc(ADDR_MASK_HI, 32'h0000ff00);
		cmd(mi(SUB_CLR_MASK, 12'h202));
		rdc(ADDR_MASK_LO, 32'h00000000);
		rdc(ADDR_MASK_HI, 32'h0000ff00);
	endtask : t_mask
	task t_take;
		cmd(mi(SUB_SET_BASE, {3'h0, 7'h55, 2'h0}));
		cmd(mi(SUB_SET_MASK, 12'h028));
		cmd(mi(SUB_FORCE, 12'h028));
		quiet();
		cmd(mi(SUB_TURN_ON, 12'h000));
		waitTake();
		chk(v.address, {7'h55, 6'h03, 2'h0});
		quiet();
		rdc(ADDR_STATUS, 32'h00000085);
		cmd(rs(SUB_RESTORE, 6'h03));
		quiet();
		pulse(3'h1);
		waitTake();
		chk(v.line, 6'h05);
	endtask : t_take
	task t_sig;
		cmd(rs(SUB_RESTORE_SIG, 6'h05));
		n = 0;
		do begin
			@(negedge clk);
			n++;
			if (n > 20) tmo();
		end while (restoreStore.valid !== 1'b1);
		chk(restoreStore, {1'b1, RESTORE_ADDR, RESTORE_CODE});
		@(posedge clk);
		rdc(ADDR_ACTIVE_LO, 32'h0);
		cmd(rs(SUB_RESTORE_SIG, 6'h05));
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(normalIrq, 1'b0);
		@(posedge clk);
		pulse(3'h1);
	endtask : t_sig
	task t_off;
		ackDelay <= 4'h5;
		cmd(mi(SUB_TURN_OFF, 12'h000));
		cmd(mi(SUB_FORCE, 12'h008));
		quiet();
		rdc(ADDR_PEND_LO, 32'h00000008);
		cmd(mi(SUB_TURN_ON, 12'h000));
		waitTake();
		chk(v.line, 6'h03);
		rel3();
	endtask : t_off
	task t_auto;
		cmd(mi(SUB_SEL_AUTO, 12'h000));
		cmd(mi(SUB_FORCE, 12'h008));
		waitTake();
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(q[1:0], 2'b10);
		rel3();
		cmd(mi(SUB_TURN_ON, 12'h000));
		cmd(mi(SUB_FORCE, 12'h008));
		waitTake();
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(q[1:0], 2'b10);
		rel3();
		cmd(mi(SUB_DESEL_AUTO, 12'h000));
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(q[1], 1'b0);
	endtask : t_auto
	task t_abn;
		cmd(mi(SUB_TURN_OFF, 12'h000));
		pulse(3'h2);
		for (int k = 0; k < 2; k++) begin
			cmd(mi(SUB_TURN_ON, 12'h000));
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk(q[0], k[0]);
		end
		pulse(3'h2);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(q[0], 1'b0);
		cmd(mi(SUB_SEL_AUTO, 12'h000));
		cmd(mi(SUB_TURN_ON, 12'h000));
		pulse(3'h4);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(q[1:0], 2'b00);
	endtask : t_abn
	task t_clear;
		cmd(mi(SUB_CLR_MASK, 12'h008));
		cmd(mi(SUB_FORCE, 12'h008));
		cmd(mi(SUB_SEL_AUTO, 12'h000));
		cmd(mi(SUB_TURN_ON, 12'h000));
		cmd({8'h00, OPC_CLEAR, 18'h0});
		rdc(ADDR_PEND_LO, 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(q[1:0], 2'b00);
		rdc(ADDR_MASK_LO, 32'h00000020);
		cmd(mi(SUB_SET_MASK, 12'h008));
		cmd(mi(SUB_TURN_ON, 12'h000));
		cmd(mi(SUB_FORCE, 12'h008));
		waitTake();
		chk(v.address, {7'h55, 6'h03, 2'h0});
		rel3();
	endtask : t_clear
	task t_noop;
		logic [3:0] strap [4] = '{4'b0110, 4'b1010, 4'b1100, 4'b1111};
		for (int k = 0; k < 4; k++) begin
			{present, panelOn, cpuExec, cpuProg} <= strap[k];
			repeat (4) @(posedge clk);
			cmd(mi(SUB_SET_MASK, 12'hfff));
			rdc(ADDR_MASK_HI, 32'h0000ff00);
		end
		{present, panelOn, cpuExec, cpuProg} <= 4'b1110;
	endtask : t_noop
	initial begin
		{clk, resetn, psel, penable, pwrite, ev, paddr, pwdata} = '0;
		{present, panelOn, cpuExec, cpuProg, ackDelay} = {4'b1110, 4'h0};
		fails = 0;
		numChecks = 0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		t_mask();
		t_take();
		t_sig();
		t_off();
		t_auto();
		t_abn();
		t_clear();
		t_noop();
		give_verdict();
	end
endmodule : rtip_ctl_tb_top
`default_nettype wire
